// ==== hw/ctx_pkg.sv ====
// Purpose: shared constants for the execution-context unit
// Assumes: 32-bit status word, one core clock
// Notes: high-half bit layout is a local choice
package ctx_pkg;
  // status word low half
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_Q = 4;
  localparam int FLAG_L = 5;
  localparam int FLAG_T = 14;
  localparam int FLAG_R = 15;
  localparam logic [15:0] LOW_WMASK = 16'hC03F;
  localparam logic [15:0] LOW_RESET = 16'h0000;
  // status word high half
  localparam int MODE_LSB = 22;
  localparam int MODE_W = 3;
  localparam int MASK_LSB = 17;
  localparam int DEBUG_BIT = 27;
  localparam int SECURE_BIT = 31;
  localparam int GLOBAL_MASK_BIT = 16;
  localparam logic [31:0] HIGH_WMASK = 32'h001F0000;
  // system register offsets (byte addresses)
  localparam logic [9:0] OFF_STATUS = 10'h000;
  localparam logic [9:0] OFF_SEC_SYSTEM_STACK_POINTER = 10'h1B0;
  localparam logic [9:0] OFF_SEC_APPLICATION_STACK_POINTER = 10'h1B4;
  // event codes
  localparam logic [2:0] EV_NONE = 3'h0;
  localparam logic [2:0] EV_NMI = 3'h1;
  localparam logic [2:0] EV_EXC = 3'h2;
  localparam logic [2:0] EV_INTERRUPT_LEVEL_THREE = 3'h3;
  localparam logic [2:0] EV_INT2 = 3'h4;
  localparam logic [2:0] EV_INT1 = 3'h5;
  localparam logic [2:0] EV_INTERRUPT_LEVEL_ZERO = 3'h6;
  localparam logic [2:0] RANK_NONE = 3'h7;
  // mode encodings in the status word
  typedef enum logic [2:0] {
    MODE_APP = 3'h0,
    MODE_SUP = 3'h1,
    MODE_INTERRUPT_LEVEL_ZERO = 3'h2,
    MODE_INT1 = 3'h3,
    MODE_INT2 = 3'h4,
    MODE_INTERRUPT_LEVEL_THREE = 3'h5,
    MODE_EXC = 3'h6,
    MODE_NMI = 3'h7
  } mode_e;
  // sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_PUSH = 3'b010,
    ST_POP = 3'b100
  } seq_e;
  // stack frame words on interrupt entry: r8..r12, status, return address
  localparam logic [2:0] FRAME_INT = 3'h7;
  localparam logic [2:0] FRAME_EXC = 3'h2;
endpackage

// ==== hw/ctx_rank.sv ====
// Purpose: fixed priority pick among pending events
// Assumes: request bit 0 nmi, 1 exception, 2..5 interrupt levels 3..0
// Notes: purely combinational
`timescale 1ns/1ps
module ctx_rank (
  // requests
  input wire logic [5:0] req_in,
  input wire logic [3:0] mask_in,
  // result
  output logic [2:0] rank_out
);
  import ctx_pkg::*;
  logic [5:0] eff;
  always_comb begin
    eff = req_in & {~mask_in[0], ~mask_in[1], ~mask_in[2], ~mask_in[3],
                    2'b11};
    rank_out = RANK_NONE;
    for (int i = 5; i >= 0; i--) begin
      if (eff[i]) begin
        rank_out = 3'(i + 1);
      end
    end
  end
endmodule // ctx_rank

// ==== hw/ctx_unit.sv ====
// Purpose: execution mode, status word and stack context control
// Assumes: core drives system-register move strobes and stack port
// Notes: frame words leave on a push port, one per cycle
`timescale 1ns/1ps
module ctx_unit (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  // event requests
  input wire logic NMI_REQ_IN,
  input wire logic EXC_REQ_IN,
  input wire logic [3:0] IRQ_LEVEL_IN,
  input wire logic [31:0] RETURN_ADDR_IN,
  input wire logic [31:0] HANDLER_SP_IN,
  // instruction controls
  input wire logic RETURN_EVENT_IN,
  input wire logic DEBUG_ENTER_IN,
  input wire logic DEBUG_RETURN_IN,
  input wire logic PRIV_INSN_IN,
  input wire logic SECURE_ACCESS_IN,
  input wire logic SECURE_ENTER_IN,
  input wire logic SECURE_EXIT_IN,
  // system register moves
  input wire logic SR_WRITE_IN,
  input wire logic SR_READ_IN,
  input wire logic [9:0] SR_ADDR_IN,
  input wire logic [31:0] SR_WDATA_IN,
  // flag update from the alu
  input wire logic FLAG_WE_IN,
  input wire logic [4:0] FLAG_IN,
  // stack frame data
  input wire logic [31:0] GPR_WORD_IN,
  input wire logic [31:0] POP_WORD_IN,
  // outputs
  output logic [31:0] STATUS_WORD_OUT,
  output logic [31:0] SR_RDATA_OUT,
  output logic PRIV_FAULT_OUT,
  output logic SECURE_FAULT_OUT,
  output logic PUSH_VALID_OUT,
  output logic [31:0] PUSH_WORD_OUT,
  output logic POP_REQ_OUT,
  output logic [2:0] FRAME_IDX_OUT,
  output logic [31:0] ACTIVE_SP_OUT,
  output logic BUSY_OUT
);
  import ctx_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [31:0] sr_q, sr_d;
  logic [31:0] application_stack_pointer_q, application_stack_pointer_d, system_stack_pointer_q, system_stack_pointer_d, secure_stack_pointer_q, secure_stack_pointer_d;
  logic [31:0] rdata_q, rdata_d, push_q, push_d;
  logic priv_f_q, priv_f_d, sec_f_q, sec_f_d;
  logic push_v_q, push_v_d, pop_q, pop_d;
  logic [2:0] idx_q, idx_d, len_q, len_d;
  logic [31:0] saved_sr_q, saved_sr_d;
  seq_e st_q, st_d;
  logic [2:0] rank, cur_rank;
  logic [2:0] mode;
  logic privileged, in_debug, in_secure, take;
  logic [5:0] reqs;

  assign reqs = {IRQ_LEVEL_IN[0], IRQ_LEVEL_IN[1], IRQ_LEVEL_IN[2],
                 IRQ_LEVEL_IN[3], EXC_REQ_IN, NMI_REQ_IN};
  assign mode = sr_q[MODE_LSB +: MODE_W];
  assign in_debug = sr_q[DEBUG_BIT];
  assign in_secure = sr_q[SECURE_BIT];
  assign privileged = (mode != MODE_APP) || in_debug;

  ctx_rank u_rank (
    .req_in(reqs),
    .mask_in(sr_q[MASK_LSB +: 4]),
    .rank_out(rank)
  );

  // rank of the mode now running; supervisor and application have none
  always_comb begin
    unique case (mode)
      MODE_NMI: cur_rank = EV_NMI;
      MODE_EXC: cur_rank = EV_EXC;
      MODE_INTERRUPT_LEVEL_THREE: cur_rank = EV_INTERRUPT_LEVEL_THREE;
      MODE_INT2: cur_rank = EV_INT2;
      MODE_INT1: cur_rank = EV_INT1;
      MODE_INTERRUPT_LEVEL_ZERO: cur_rank = EV_INTERRUPT_LEVEL_ZERO;
      default: cur_rank = RANK_NONE;
    endcase
  end
  // lower rank number wins; equal rank never preempts
  assign take = (st_q == ST_RUN) && (rank < cur_rank);

  function automatic logic [2:0] rank_mode(input logic [2:0] r);
    unique case (r)
      EV_NMI: rank_mode = MODE_NMI;
      EV_EXC: rank_mode = MODE_EXC;
      EV_INTERRUPT_LEVEL_THREE: rank_mode = MODE_INTERRUPT_LEVEL_THREE;
      EV_INT2: rank_mode = MODE_INT2;
      EV_INT1: rank_mode = MODE_INT1;
      default: rank_mode = MODE_INTERRUPT_LEVEL_ZERO;
    endcase
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    sr_d = sr_q;
    application_stack_pointer_d = application_stack_pointer_q;
    system_stack_pointer_d = system_stack_pointer_q;
    secure_stack_pointer_d = secure_stack_pointer_q;
    rdata_d = rdata_q;
    push_d = push_q;
    push_v_d = 1'b0;
    pop_d = 1'b0;
    priv_f_d = 1'b0;
    sec_f_d = 1'b0;
    idx_d = idx_q;
    len_d = len_q;
    saved_sr_d = saved_sr_q;
    st_d = st_q;
    if (FLAG_WE_IN) begin
      sr_d[4:0] = FLAG_IN;
    end
    unique case (st_q)
      ST_RUN: begin
        if (take) begin
          saved_sr_d = sr_q;
          sr_d[MODE_LSB +: MODE_W] = rank_mode(rank);
          sr_d[GLOBAL_MASK_BIT] = 1'b1;
          // interrupt levels save the full frame, nmi and exceptions only status+return
          len_d = (rank >= EV_INTERRUPT_LEVEL_THREE) ? FRAME_INT : FRAME_EXC;
          idx_d = 3'h0;
          st_d = ST_PUSH;
        end else if (RETURN_EVENT_IN && privileged) begin
          len_d = (mode == MODE_EXC || mode == MODE_NMI) ? FRAME_EXC
                                                         : FRAME_INT;
          idx_d = 3'h0;
          st_d = ST_POP;
        end else if (DEBUG_ENTER_IN && !in_debug) begin
          sr_d[DEBUG_BIT] = 1'b1;
          sr_d[MASK_LSB +: 4] = 4'hF;
        end else if (DEBUG_RETURN_IN && in_debug) begin
          sr_d[DEBUG_BIT] = 1'b0;
        end else if (SECURE_ENTER_IN) begin
          sr_d[SECURE_BIT] = 1'b1;
        end else if (SECURE_EXIT_IN && in_secure) begin
          sr_d[SECURE_BIT] = 1'b0;
        end
        if (PRIV_INSN_IN && !privileged) begin
          priv_f_d = 1'b1;
        end
        if (SECURE_ACCESS_IN && !in_secure) begin
          sec_f_d = 1'b1;
        end
        if ((SR_WRITE_IN || SR_READ_IN) && !take) begin
          if (!privileged) begin
            priv_f_d = 1'b1;
          end else if (SR_ADDR_IN == OFF_STATUS) begin
            if (SR_WRITE_IN) begin
              sr_d[15:0] = SR_WDATA_IN[15:0] & LOW_WMASK;
              // writing the mode field is a software mode change
              sr_d[MODE_LSB +: MODE_W] = SR_WDATA_IN[MODE_LSB +: MODE_W];
              sr_d = (sr_d & ~HIGH_WMASK) | (SR_WDATA_IN & HIGH_WMASK);
            end
            rdata_d = sr_q;
          end else if (SR_ADDR_IN == OFF_SEC_SYSTEM_STACK_POINTER ||
                       SR_ADDR_IN == OFF_SEC_APPLICATION_STACK_POINTER) begin
            if (!in_secure && !in_debug) begin
              sec_f_d = 1'b1;
              rdata_d = 32'h00000000;
            end else begin
              if (SR_WRITE_IN) begin
                secure_stack_pointer_d = SR_WDATA_IN;
              end
              rdata_d = secure_stack_pointer_q;
            end
          end else begin
            rdata_d = 32'h00000000;
          end
        end
      end
      ST_PUSH: begin
        push_v_d = 1'b1;
        if (idx_q == len_q - 3'h2) begin
          push_d = saved_sr_q;
        end else if (idx_q == len_q - 3'h1) begin
          push_d = RETURN_ADDR_IN;
        end else begin
          push_d = GPR_WORD_IN;
        end
        system_stack_pointer_d = HANDLER_SP_IN;
        idx_d = idx_q + 3'h1;
        if (idx_q == len_q - 3'h1) begin
          st_d = ST_RUN;
        end
      end
      ST_POP: begin
        pop_d = 1'b1;
        // the status word is restored from the frame
        if (idx_q == len_q - 3'h2) begin
          sr_d = POP_WORD_IN;
          // a frame pop must not enter or leave debug state
          sr_d[DEBUG_BIT] = sr_q[DEBUG_BIT];
        end
        idx_d = idx_q + 3'h1;
        if (idx_q == len_q - 3'h1) begin
          st_d = ST_RUN;
        end
      end
      default: st_d = ST_RUN;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      sr_q <= {16'h0000, LOW_RESET};
      sr_q[MODE_LSB +: MODE_W] <= MODE_SUP;
      application_stack_pointer_q <= 32'h00000000;
      system_stack_pointer_q <= 32'h00000000;
      secure_stack_pointer_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      push_q <= 32'h00000000;
      push_v_q <= 1'b0;
      pop_q <= 1'b0;
      priv_f_q <= 1'b0;
      sec_f_q <= 1'b0;
      idx_q <= 3'h0;
      len_q <= 3'h0;
      saved_sr_q <= 32'h00000000;
      st_q <= ST_RUN;
    end else begin
      sr_q <= sr_d;
      application_stack_pointer_q <= application_stack_pointer_d;
      system_stack_pointer_q <= system_stack_pointer_d;
      secure_stack_pointer_q <= secure_stack_pointer_d;
      rdata_q <= rdata_d;
      push_q <= push_d;
      push_v_q <= push_v_d;
      pop_q <= pop_d;
      priv_f_q <= priv_f_d;
      sec_f_q <= sec_f_d;
      idx_q <= idx_d;
      len_q <= len_d;
      saved_sr_q <= saved_sr_d;
      st_q <= st_d;
    end
  end

  logic [31:0] sp_out_q;
  logic [2:0] idx_out_q;
  logic busy_q;
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      sp_out_q <= 32'h00000000;
      idx_out_q <= 3'h0;
      busy_q <= 1'b0;
    end else begin
      // stack selection follows the mode after this edge
      sp_out_q <= sr_d[SECURE_BIT] ? secure_stack_pointer_d :
                  (sr_d[MODE_LSB +: MODE_W] == MODE_APP) ? application_stack_pointer_d
                                                         : system_stack_pointer_d;
      idx_out_q <= idx_q;
      busy_q <= (st_d != ST_RUN);
    end
  end

  assign STATUS_WORD_OUT = sr_q;
  assign SR_RDATA_OUT = rdata_q;
  assign PRIV_FAULT_OUT = priv_f_q;
  assign SECURE_FAULT_OUT = sec_f_q;
  assign PUSH_VALID_OUT = push_v_q;
  assign PUSH_WORD_OUT = push_q;
  assign POP_REQ_OUT = pop_q;
  assign FRAME_IDX_OUT = idx_out_q;
  assign ACTIVE_SP_OUT = sp_out_q;
  assign BUSY_OUT = busy_q;
endmodule // ctx_unit

// ==== verification/ctx_checker.sv ====
// Purpose: port assertions for ctx_unit
// Assumes: one clock, synchronous reset
// Notes: mode field sits in status bits 24:22
`timescale 1ns/1ps
module ctx_checker (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  // watched inputs
  input wire logic NMI_REQ_IN,
  input wire logic EXC_REQ_IN,
  input wire logic [3:0] IRQ_LEVEL_IN,
  input wire logic RETURN_EVENT_IN,
  input wire logic DEBUG_RETURN_IN,
  input wire logic PRIV_INSN_IN,
  input wire logic SECURE_ACCESS_IN,
  input wire logic SR_WRITE_IN,
  // watched outputs
  input wire logic [31:0] STATUS_WORD_OUT,
  input wire logic PRIV_FAULT_OUT,
  input wire logic SECURE_FAULT_OUT,
  input wire logic PUSH_VALID_OUT,
  input wire logic BUSY_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic [2:0] md;
  logic dbg;
  assign md = STATUS_WORD_OUT[24:22];
  assign dbg = STATUS_WORD_OUT[27];
  sequence s_irq3_take;
    !BUSY_OUT && md == 3'h1 && IRQ_LEVEL_IN[3] && !NMI_REQ_IN && !EXC_REQ_IN
      && !dbg && STATUS_WORD_OUT[20:16] == 5'h00;
  endsequence
  sequence s_frame7;
    md == 3'h5 && BUSY_OUT ##1 PUSH_VALID_OUT [*7] ##1 !BUSY_OUT;
  endsequence
  property p_irq_frame; s_irq3_take |=> s_frame7; endproperty
  a_irq_frame: assert property (p_irq_frame)
    else $error("bad interrupt frame");
  property p_rst_sup;
    $fell(SYS_RST_IN) |-> STATUS_WORD_OUT == 32'h00400000;
  endproperty
  a_rst_sup: assert property (p_rst_sup)
    else $error("bad status after reset");
  property p_nmi_pre;
    !BUSY_OUT && NMI_REQ_IN && !dbg && md != 3'h7 |=> md == 3'h7;
  endproperty
  a_nmi_pre: assert property (p_nmi_pre)
    else $error("nmi not taken");
  property p_no_pre;
    !BUSY_OUT && md == 3'h7 && !RETURN_EVENT_IN && !SR_WRITE_IN
      |=> md == 3'h7;
  endproperty
  a_no_pre: assert property (p_no_pre)
    else $error("nmi mode left");
  property p_app_fault;
    !BUSY_OUT && md == 3'h0 && !dbg && (PRIV_INSN_IN || (SR_WRITE_IN &&
      !NMI_REQ_IN && !EXC_REQ_IN && IRQ_LEVEL_IN == 4'h0))
      |=> PRIV_FAULT_OUT;
  endproperty
  a_app_fault: assert property (p_app_fault)
    else $error("missing privilege fault");
  property p_sys_ok;
    PRIV_FAULT_OUT |-> $past(md) == 3'h0 && !$past(dbg);
  endproperty
  a_sys_ok: assert property (p_sys_ok)
    else $error("fault in privileged mode");
  property p_dbg_mask; $rose(dbg) |-> STATUS_WORD_OUT[20:17] == 4'hF; endproperty
  a_dbg_mask: assert property (p_dbg_mask)
    else $error("levels open on debug entry");
  property p_dbg_hold; dbg && !DEBUG_RETURN_IN |=> dbg; endproperty
  a_dbg_hold: assert property (p_dbg_hold)
    else $error("debug left early");
  property p_sec_fault;
    !BUSY_OUT && SECURE_ACCESS_IN && !STATUS_WORD_OUT[31] && !dbg
      |=> SECURE_FAULT_OUT;
  endproperty
  a_sec_fault: assert property (p_sec_fault)
    else $error("missing secure fault");
endmodule // ctx_checker
bind ctx_unit ctx_checker i_ctx_checker (
  .CLK_SYS_IN, .SYS_RST_IN, .NMI_REQ_IN, .EXC_REQ_IN, .IRQ_LEVEL_IN,
  .RETURN_EVENT_IN, .DEBUG_RETURN_IN, .PRIV_INSN_IN, .SECURE_ACCESS_IN,
  .SR_WRITE_IN, .STATUS_WORD_OUT, .PRIV_FAULT_OUT, .SECURE_FAULT_OUT,
  .PUSH_VALID_OUT, .BUSY_OUT
);

// ==== verification/ctx_partner.sv ====
// Purpose: stack side model holding one pushed frame
// Assumes: one frame outstanding at a time
// Notes: app_ret_in models an os return into application mode
`timescale 1ns/1ps
module ctx_partner (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // core side
  input wire logic busy_in,
  input wire logic push_valid_in,
  input wire logic [31:0] push_word_in,
  input wire logic pop_req_in,
  input wire logic [2:0] frame_idx_in,
  input wire logic app_ret_in,
  output logic [31:0] gpr_word_out,
  output logic [31:0] pop_word_out
);
  logic [31:0] frame_q [0:7];
  logic [2:0] ri_q;
  logic [7:0] pops_q;
  // ri_q counts busy cycles, so it equals the core's frame index
  assign gpr_word_out = 32'h00000A00 | 32'(ri_q);
  // saved status loses its mode field only when the scenario asks
  assign pop_word_out = (app_ret_in && ri_q == 3'h5) ?
    (frame_q[ri_q] & 32'hFE3FFFFF) : frame_q[ri_q];
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ri_q <= 3'h0;
      pops_q <= 8'h00;
    end else begin
      if (busy_in) begin
        ri_q <= ri_q + 3'h1;
      end else begin
        ri_q <= 3'h0;
      end
      // the last word of a frame arrives after busy has dropped
      if (push_valid_in) begin
        frame_q[frame_idx_in] <= push_word_in;
      end
      if (pop_req_in) begin
        pops_q <= pops_q + 8'h01;
      end
    end
  end
endmodule // ctx_partner

// ==== verification/tb_top.sv ====
// Purpose: directed bench for ctx_unit
// Assumes: inputs change 1 ns after the rising edge
// Notes: tb signals reuse the port names so the unit binds with .*
`timescale 1ns/1ps
module tb_top;
  logic CLK_SYS_IN, SYS_RST_IN, NMI_REQ_IN, EXC_REQ_IN, RETURN_EVENT_IN;
  logic DEBUG_ENTER_IN, DEBUG_RETURN_IN, PRIV_INSN_IN, SECURE_ACCESS_IN;
  logic SECURE_ENTER_IN, SECURE_EXIT_IN, SR_WRITE_IN, SR_READ_IN;
  logic FLAG_WE_IN, PRIV_FAULT_OUT, SECURE_FAULT_OUT, PUSH_VALID_OUT;
  logic POP_REQ_OUT, BUSY_OUT, app_ret;
  logic [3:0] IRQ_LEVEL_IN;
  logic [9:0] SR_ADDR_IN;
  logic [4:0] FLAG_IN;
  logic [2:0] FRAME_IDX_OUT, md;
  logic [31:0] RETURN_ADDR_IN, HANDLER_SP_IN, SR_WDATA_IN, GPR_WORD_IN;
  logic [31:0] POP_WORD_IN, STATUS_WORD_OUT, SR_RDATA_OUT, PUSH_WORD_OUT;
  logic [31:0] ACTIVE_SP_OUT;
  int errors = 0, cmp_count = 0, cyc = 0;
  assign md = STATUS_WORD_OUT[24:22];
  ctx_unit i_ctx_unit (.*);
  ctx_partner i_ctx_partner (
    .clk_in(CLK_SYS_IN), .rst_in(SYS_RST_IN), .busy_in(BUSY_OUT),
    .push_valid_in(PUSH_VALID_OUT), .push_word_in(PUSH_WORD_OUT),
    .pop_req_in(POP_REQ_OUT), .frame_idx_in(FRAME_IDX_OUT),
    .app_ret_in(app_ret), .gpr_word_out(GPR_WORD_IN),
    .pop_word_out(POP_WORD_IN)
  );
  initial begin
    CLK_SYS_IN = 1'b0;
    forever #5 CLK_SYS_IN = ~CLK_SYS_IN;
  end
  task automatic close_out();
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // the whole run is under 1000 cycles
  always @(posedge CLK_SYS_IN) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge CLK_SYS_IN);
    #1;
  endtask
  task automatic pls(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic rst();
    SYS_RST_IN = 1'b1;
    tick(8);
    SYS_RST_IN = 1'b0;
  endtask
  // event i has rank i+1: nmi, exception, levels three down to zero
  task automatic ev(int i);
    {NMI_REQ_IN, EXC_REQ_IN, IRQ_LEVEL_IN} = 6'h20 >> i;
    tick();
    {NMI_REQ_IN, EXC_REQ_IN, IRQ_LEVEL_IN} = 6'h00;
  endtask
  task automatic idle();
    int k = 0;
    while (BUSY_OUT !== 1'b0 && k < 50) begin
      tick();
      k++;
    end
    if (k == 50) chk("busy", 32'h1, 32'h0);
  endtask
  task automatic ret();
    pls(RETURN_EVENT_IN);
    tick();
    idle();
  endtask
  task automatic sr_wr(logic [9:0] a, logic [31:0] d);
    SR_ADDR_IN = a;
    SR_WDATA_IN = d;
    pls(SR_WRITE_IN);
  endtask
  task automatic sr_rd(logic [9:0] a, logic [31:0] e, string n);
    SR_ADDR_IN = a;
    pls(SR_READ_IN);
    chk(n, SR_RDATA_OUT, e);
  endtask
  initial begin
    {NMI_REQ_IN, EXC_REQ_IN, IRQ_LEVEL_IN, RETURN_EVENT_IN, DEBUG_ENTER_IN,
     DEBUG_RETURN_IN, PRIV_INSN_IN, SECURE_ACCESS_IN, SECURE_ENTER_IN,
     SECURE_EXIT_IN, SR_WRITE_IN, SR_READ_IN, SR_ADDR_IN, SR_WDATA_IN,
     FLAG_WE_IN, FLAG_IN, app_ret} = '0;
    RETURN_ADDR_IN = 32'h00001234;
    HANDLER_SP_IN = 32'h00002000;
    rst();
    chk("reset", STATUS_WORD_OUT, 32'h00400000);
    for (int i = 0; i < 6; i++) begin
      int s;
      s = (i < 2) ? 0 : 5;
      ev(i);
      chk("taken", 32'(md), 32'(7 - i));
      idle();
      tick();
      chk("saved", i_ctx_partner.frame_q[s], 32'h00400000);
      chk("raddr", i_ctx_partner.frame_q[s + 1], 32'h00001234);
      if (i >= 2) chk("r12", i_ctx_partner.frame_q[4], 32'h00000A04);
      ret();
      chk("back", 32'(md), 32'h1);
    end
    tick();
    chk("pops", 32'(i_ctx_partner.pops_q), 32'h00000020);
    chk("sp", ACTIVE_SP_OUT, 32'h00002000);
    ev(5);
    idle();
    ev(2);
    chk("pre", 32'(md), 32'h5);
    idle();
    ev(3);
    tick();
    chk("nopre", 32'(md), 32'h5);
    ev(0);
    chk("nmi", 32'(md), 32'h7);
    idle();
    rst();
    FLAG_IN = 5'h15;
    pls(FLAG_WE_IN);
    chk("flags", 32'(STATUS_WORD_OUT[4:0]), 32'h15);
    sr_wr(10'h000, 32'hFE7FFFFF);
    sr_rd(10'h000, 32'h005FC03F, "sr");
    ev(5);
    tick();
    chk("masked", 32'(md), 32'h1);
    sr_wr(10'h000, 32'h00400000);
    sr_rd(10'h004, 32'h00000000, "unmap");
    app_ret = 1'b1;
    ev(5);
    idle();
    ret();
    app_ret = 1'b0;
    chk("app", STATUS_WORD_OUT, 32'h00000000);
    pls(PRIV_INSN_IN);
    chk("ifault", 32'(PRIV_FAULT_OUT), 32'h1);
    sr_wr(10'h000, 32'h0000001F);
    chk("wfault", 32'(PRIV_FAULT_OUT), 32'h1);
    chk("wnone", STATUS_WORD_OUT, 32'h00000000);
    pls(SECURE_ACCESS_IN);
    chk("sfault", 32'(SECURE_FAULT_OUT), 32'h1);
    pls(DEBUG_ENTER_IN);
    chk("dmask", 32'(STATUS_WORD_OUT[27:17]), 32'h40F);
    pls(PRIV_INSN_IN);
    chk("dinsn", 32'(PRIV_FAULT_OUT), 32'h0);
    sr_wr(10'h000, 32'h001C0000);
    chk("unmask", 32'(STATUS_WORD_OUT[20:16]), 32'h1C);
    tick(4);
    chk("dhold", 32'(STATUS_WORD_OUT[27]), 32'h1);
    pls(DEBUG_RETURN_IN);
    chk("dexit", 32'(STATUS_WORD_OUT[27]), 32'h0);
    rst();
    sr_wr(10'h1B0, 32'h00005EC0);
    chk("ssf", 32'(SECURE_FAULT_OUT), 32'h1);
    sr_rd(10'h1B0, 32'h00000000, "sshide");
    pls(SECURE_ENTER_IN);
    chk("ssin", 32'(STATUS_WORD_OUT[31]), 32'h1);
    sr_wr(10'h1B4, 32'h00003F00);
    sr_rd(10'h1B4, 32'h00003F00, "sssp");
    chk("secsp", ACTIVE_SP_OUT, 32'h00003F00);
    pls(SECURE_EXIT_IN);
    chk("ssout", 32'(STATUS_WORD_OUT[31]), 32'h0);
    close_out();
  end
endmodule // tb_top
